/* File: common/itto_pkg.sv */
package itto_pkg;

    // ==========================================================
    // Bus geometry and register map.
    // ==========================================================
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_BREG = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_CTRL = 8'h10;
    localparam logic [7:0] OFF_TIMER = 8'h14;
    localparam logic [7:0] OFF_RELOAD = 8'h18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Field positions.
    // ==========================================================
    localparam int ST_IME = 0;
    localparam int ST_EXT0 = 1;
    localparam int ST_SKIP = 2;
    localparam int ST_PIN = 3;
    localparam int EXT0_EN_BIT = 0;
    localparam int PIN_POL_BIT = 2;

    // ==========================================================
    // Reset values.
    // ==========================================================
    localparam logic [3:0] RST_NIB = 4'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic RST_BIT = 1'b0;
    localparam logic RST_READY = 1'b1;

    // ==========================================================
    // Operation codes written to the command register.
    // ==========================================================
    typedef enum logic [4:0] {
        op_nop = 5'h00,
        op_irq_mask = 5'h01,
        op_irq_unmask = 5'h02,
        op_ext0_test = 5'h03,
        op_pin_test = 5'h04,
        op_rd_irq1 = 5'h05,
        op_wr_irq1 = 5'h06,
        op_rd_irq2 = 5'h07,
        op_wr_irq2 = 5'h08,
        op_rd_pinctl = 5'h09,
        op_wr_pinctl = 5'h0A,
        op_wr_aux = 5'h0B,
        op_rd_tc1 = 5'h0C,
        op_wr_tc1 = 5'h0D,
        op_rd_tc2 = 5'h0E,
        op_wr_tc2 = 5'h0F,
        op_rd_tc5 = 5'h10,
        op_wr_tc5 = 5'h11,
        op_rd_tc6 = 5'h12,
        op_wr_tc6 = 5'h13,
        op_rd_presc = 5'h14,
        op_wr_presc = 5'h15,
        op_rd_tmr1 = 5'h16,
        op_wr_tmr1 = 5'h17,
        op_wr_tmr1_second = 5'h18
    } itto_op_t;

    // ==========================================================
    // Whole state of the block.
    // ==========================================================
    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic w_full;
        logic w_lane0;
        logic [7:0] w_data;
        logic [4:0] last_op;
        logic [3:0] acc;
        logic [3:0] breg;
        logic irq_master_enable;
        logic ext0_request_flag;
        logic skip;
        logic pin_s1;
        logic pin_s2;
        logic [3:0] irq_control_first;
        logic [3:0] irq_control_second;
        logic [3:0] ext_pin_control;
        logic timer_aux_control;
        logic [3:0] timer_ctrl_one;
        logic [3:0] timer_ctrl_two;
        logic [3:0] timer_ctrl_five;
        logic [3:0] timer_ctrl_six;
        logic [7:0] prescaler;
        logic [7:0] prescaler_reload;
        logic [7:0] timer1;
        logic [7:0] timer1_first_reload;
        logic [7:0] timer1_second_reload;
    } itto_state_t;

endpackage : itto_pkg

/* File: rtl/itto_core.sv */
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - Mask operation clears the master interrupt enable flag.
// - Unmask operation sets the master interrupt enable flag.
// - Enable bit 0 and request flag 1: flag test clears flag, skips next.
// - Enable bit 0 and request flag 0: flag test does not skip.
// - Enable bit 1: flag test is a no-operation.
// - The external-0 enable bit is bit 0 of first interrupt control.
// - Polarity 0: pin test skips when the pin is low.
// - Polarity 1: pin test skips when the pin is high.
// - The polarity bit is bit 2 of the pin control register.
// - First interrupt control can be read to and written from the accumulator.
// - Second interrupt control can be read to and written from the accumulator.
// - Pin control can be read to and written from the accumulator.
// - Auxiliary timer control is write-only from the accumulator.
// - Timer control one can be read and written via the accumulator.
// - Timer control two can be read and written via the accumulator.
// - Timer control five can be read and written via the accumulator.
// - Timer control six can be read and written via the accumulator.
// - Prescaler read puts upper nibble in B, lower nibble in accumulator.
// - Prescaler write loads count and reload together from B and accumulator.
// - Timer 1 read puts count bits 7..4 in B, 3..0 in accumulator.
// - Timer 1 write loads count and first reload from B and accumulator.
// - Second reload write loads only the second reload from B and accumulator.
module itto_core (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [itto_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [itto_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_int_pin,
    input wire logic ext0_event,
    output logic irq_master_enable,
    output logic ext0_request_flag,
    output logic skip_pending,
    output logic timer_aux_control
);

    // ==========================================================
    // Register read decode.
    // ==========================================================
    function automatic logic [32:0] itto_read(
        input logic [itto_pkg::ADDR_W-1:0] addr,
        input itto_pkg::itto_state_t st
    );
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        unique case (addr)
            itto_pkg::OFF_CMD: r[4:0] = st.last_op;
            itto_pkg::OFF_ACC: r[3:0] = st.acc;
            itto_pkg::OFF_BREG: r[3:0] = st.breg;
            itto_pkg::OFF_STATUS: begin
                r[itto_pkg::ST_IME] = st.irq_master_enable;
                r[itto_pkg::ST_EXT0] = st.ext0_request_flag;
                r[itto_pkg::ST_SKIP] = st.skip;
                r[itto_pkg::ST_PIN] = st.pin_s2;
            end
            itto_pkg::OFF_CTRL: r[27:0] = {st.timer_ctrl_six, st.timer_ctrl_five,
                st.timer_ctrl_two, st.timer_ctrl_one, st.ext_pin_control,
                st.irq_control_second, st.irq_control_first};
            itto_pkg::OFF_TIMER: r[15:0] = {st.timer1, st.prescaler};
            itto_pkg::OFF_RELOAD: r[23:0] = {st.timer1_second_reload,
                st.timer1_first_reload, st.prescaler_reload};
            default: r[32] = 1'b0;
        endcase
        return r;
    endfunction : itto_read

    // ==========================================================
    // Write address check.
    // ==========================================================
    function automatic logic itto_wr_ok(
        input logic [itto_pkg::ADDR_W-1:0] addr
    );
        return (addr == itto_pkg::OFF_CMD) || (addr == itto_pkg::OFF_ACC) ||
            (addr == itto_pkg::OFF_BREG) || (addr == itto_pkg::OFF_STATUS) ||
            (addr == itto_pkg::OFF_CTRL) || (addr == itto_pkg::OFF_TIMER) ||
            (addr == itto_pkg::OFF_RELOAD);
    endfunction : itto_wr_ok

    itto_pkg::itto_state_t s;
    itto_pkg::itto_state_t next_s;

    // ==========================================================
    // Next state.
    // ==========================================================
    always_comb begin
        itto_pkg::itto_op_t op;
        logic [32:0] rd;
        logic do_wr;
        logic pin_skip;
        op = itto_pkg::op_nop;
        rd = itto_read(s_axi_araddr, s);
        do_wr = s.aw_full && s.w_full && !s.bvalid;
        pin_skip = 1'b0;
        next_s = s;

        next_s.pin_s1 = ext_int_pin;
        next_s.pin_s2 = s.pin_s1;

        // Write channels are taken independently, in either order.
        if (s.awready && s_axi_awvalid) begin
            next_s.aw_full = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s.wready && s_axi_wvalid) begin
            next_s.w_full = 1'b1;
            next_s.w_data = s_axi_wdata[7:0];
            next_s.w_lane0 = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        if (do_wr) begin
            next_s.aw_full = 1'b0;
            next_s.w_full = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = itto_wr_ok(s.aw_addr) ? itto_pkg::RESP_OKAY : itto_pkg::RESP_SLVERR;
            if (s.w_lane0 && s.aw_addr == itto_pkg::OFF_ACC) begin
                next_s.acc = s.w_data[3:0];
            end
            if (s.w_lane0 && s.aw_addr == itto_pkg::OFF_BREG) begin
                next_s.breg = s.w_data[3:0];
            end
            if (s.w_lane0 && s.aw_addr == itto_pkg::OFF_CMD) begin
                next_s.last_op = s.w_data[4:0];
                op = itto_pkg::itto_op_t'(s.w_data[4:0]);
                if (s.skip) begin
                    op = itto_pkg::op_nop;
                end
                next_s.skip = 1'b0;
                unique case (op)
                    itto_pkg::op_nop: next_s.skip = 1'b0;
                    itto_pkg::op_irq_mask: next_s.irq_master_enable = 1'b0;
                    itto_pkg::op_irq_unmask: next_s.irq_master_enable = 1'b1;
                    itto_pkg::op_ext0_test: begin
                        if (!s.irq_control_first[itto_pkg::EXT0_EN_BIT]) begin
                            if (s.ext0_request_flag) begin
                                next_s.ext0_request_flag = 1'b0;
                                next_s.skip = 1'b1;
                            end else begin
                                next_s.skip = 1'b0;
                            end
                        end
                    end
                    itto_pkg::op_pin_test: begin
                        if (s.ext_pin_control[itto_pkg::PIN_POL_BIT]) begin
                            pin_skip = s.pin_s2;
                        end else begin
                            pin_skip = !s.pin_s2;
                        end
                        next_s.skip = pin_skip;
                    end
                    itto_pkg::op_rd_irq1: next_s.acc = s.irq_control_first;
                    itto_pkg::op_wr_irq1: next_s.irq_control_first = s.acc;
                    itto_pkg::op_rd_irq2: next_s.acc = s.irq_control_second;
                    itto_pkg::op_wr_irq2: next_s.irq_control_second = s.acc;
                    itto_pkg::op_rd_pinctl: next_s.acc = s.ext_pin_control;
                    itto_pkg::op_wr_pinctl: next_s.ext_pin_control = s.acc;
                    itto_pkg::op_wr_aux: next_s.timer_aux_control = s.acc[0];
                    itto_pkg::op_rd_tc1: next_s.acc = s.timer_ctrl_one;
                    itto_pkg::op_wr_tc1: next_s.timer_ctrl_one = s.acc;
                    itto_pkg::op_rd_tc2: next_s.acc = s.timer_ctrl_two;
                    itto_pkg::op_wr_tc2: next_s.timer_ctrl_two = s.acc;
                    itto_pkg::op_rd_tc5: next_s.acc = s.timer_ctrl_five;
                    itto_pkg::op_wr_tc5: next_s.timer_ctrl_five = s.acc;
                    itto_pkg::op_rd_tc6: next_s.acc = s.timer_ctrl_six;
                    itto_pkg::op_wr_tc6: next_s.timer_ctrl_six = s.acc;
                    itto_pkg::op_rd_presc: begin
                        next_s.breg = s.prescaler[7:4];
                        next_s.acc = s.prescaler[3:0];
                    end
                    itto_pkg::op_wr_presc: begin
                        next_s.prescaler = {s.breg, s.acc};
                        next_s.prescaler_reload = {s.breg, s.acc};
                    end
                    itto_pkg::op_rd_tmr1: begin
                        next_s.breg = s.timer1[7:4];
                        next_s.acc = s.timer1[3:0];
                    end
                    itto_pkg::op_wr_tmr1: begin
                        next_s.timer1 = {s.breg, s.acc};
                        next_s.timer1_first_reload = {s.breg, s.acc};
                    end
                    itto_pkg::op_wr_tmr1_second: next_s.timer1_second_reload = {s.breg, s.acc};
                    default: next_s.skip = 1'b0;
                endcase
            end
        end

        // A request arriving with the clear is kept.
        next_s.ext0_request_flag = next_s.ext0_request_flag | ext0_event;

        next_s.awready = !next_s.aw_full && !next_s.bvalid;
        next_s.wready = !next_s.w_full && !next_s.bvalid;

        // Read answers one edge after the address is taken.
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
            next_s.arready = 1'b1;
        end
        if (s.arready && s_axi_arvalid) begin
            next_s.arready = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.rdata = rd[31:0];
            next_s.rresp = rd[32] ? itto_pkg::RESP_OKAY : itto_pkg::RESP_SLVERR;
        end
    end

    // ==========================================================
    // State register.
    // ==========================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s.awready <= itto_pkg::RST_READY;
            s.wready <= itto_pkg::RST_READY;
            s.arready <= itto_pkg::RST_READY;
            s.bvalid <= itto_pkg::RST_BIT;
            s.bresp <= itto_pkg::RESP_OKAY;
            s.rvalid <= itto_pkg::RST_BIT;
            s.rresp <= itto_pkg::RESP_OKAY;
            s.rdata <= 32'h0000_0000;
            s.aw_full <= itto_pkg::RST_BIT;
            s.aw_addr <= itto_pkg::RST_BYTE;
            s.w_full <= itto_pkg::RST_BIT;
            s.w_lane0 <= itto_pkg::RST_BIT;
            s.w_data <= itto_pkg::RST_BYTE;
            s.last_op <= itto_pkg::op_nop;
            s.acc <= itto_pkg::RST_NIB;
            s.breg <= itto_pkg::RST_NIB;
            s.irq_master_enable <= itto_pkg::RST_BIT;
            s.ext0_request_flag <= itto_pkg::RST_BIT;
            s.skip <= itto_pkg::RST_BIT;
            s.pin_s1 <= itto_pkg::RST_BIT;
            s.pin_s2 <= itto_pkg::RST_BIT;
            s.irq_control_first <= itto_pkg::RST_NIB;
            s.irq_control_second <= itto_pkg::RST_NIB;
            s.ext_pin_control <= itto_pkg::RST_NIB;
            s.timer_aux_control <= itto_pkg::RST_BIT;
            s.timer_ctrl_one <= itto_pkg::RST_NIB;
            s.timer_ctrl_two <= itto_pkg::RST_NIB;
            s.timer_ctrl_five <= itto_pkg::RST_NIB;
            s.timer_ctrl_six <= itto_pkg::RST_NIB;
            s.prescaler <= itto_pkg::RST_BYTE;
            s.prescaler_reload <= itto_pkg::RST_BYTE;
            s.timer1 <= itto_pkg::RST_BYTE;
            s.timer1_first_reload <= itto_pkg::RST_BYTE;
            s.timer1_second_reload <= itto_pkg::RST_BYTE;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs.
    // ==========================================================
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rdata = s.rdata;
    assign irq_master_enable = s.irq_master_enable;
    assign ext0_request_flag = s.ext0_request_flag;
    assign skip_pending = s.skip;
    assign timer_aux_control = s.timer_aux_control;

endmodule : itto_core

/* File: test/itto_core_monitor.sv */
`timescale 1ns/1ps
module itto_core_monitor (
    input logic clk,
    input logic rst_n,
    input logic [itto_pkg::ADDR_W-1:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [itto_pkg::ADDR_W-1:0] s_axi_araddr,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic ext_int_pin,
    input logic ext0_event,
    input logic irq_master_enable,
    input logic ext0_request_flag,
    input logic skip_pending,
    input logic timer_aux_control
);
    // ==========================================================
    // Command sequences.
    // ==========================================================
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_cmd_wr;
        s_wr_take ##0 (s_axi_wstrb[0] && s_axi_awaddr == itto_pkg::OFF_CMD);
    endsequence
    sequence s_cmd(logic [4:0] op);
        s_cmd_wr ##0 (!skip_pending && s_axi_wdata[4:0] == op);
    endsequence
    // ==========================================================
    // Checks.
    // ==========================================================
    AST_MASK: assert property (s_cmd(5'h01) |-> ##2 !irq_master_enable)
        else $error("mask did not clear master enable");
    AST_UNMASK: assert property (s_cmd(5'h02) |-> ##2 irq_master_enable)
        else $error("unmask did not set master enable");
    AST_SKIP_EAT: assert property (skip_pending ##0 s_cmd_wr |=> $stable(irq_master_enable) [*2] ##0 !skip_pending)
        else $error("suppressed command had an effect");
    AST_SKIP_SRC: assert property ($rose(skip_pending) |-> $past(s_axi_wdata[4:0], 2) inside {5'h03, 5'h04})
        else $error("skip raised by a non-test command");
    AST_EXT0_SET: assert property (ext0_event |=> ext0_request_flag)
        else $error("request flag not set by event");
    AST_WR_RESP: assert property (s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response timing wrong");
    AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response timing wrong");
    AST_AR_HOLD: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted during response");
    AST_RD_ERR: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > itto_pkg::OFF_RELOAD
        |=> s_axi_rresp == itto_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
endmodule : itto_core_monitor

bind itto_core itto_core_monitor mon (.*);

/* File: test/itto_ext_src.sv */
`timescale 1ns/1ps
module itto_ext_src (
    input logic clk,
    input logic rst_n,
    input logic pin_req,
    input logic pulse_req,
    output logic ext_int_pin,
    output logic ext0_event
);
    // The pin level arrives with a wire delay unrelated to the clock.
    assign #3 ext_int_pin = pin_req;
    // A request is registered into the event pulse, one clock later and as long as the request.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext0_event <= 1'b0;
        end else begin
            ext0_event <= pulse_req;
        end
    end
endmodule : itto_ext_src

/* File: test/tb_irq_timer_transfer_ops.sv */
`timescale 1ns/1ps
module tb_irq_timer_transfer_ops;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, pin_req = 1'b0, pulse_req = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext_int_pin, ext0_event;
    logic irq_master_enable, ext0_request_flag, skip_pending, timer_aux_control;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int errors = 0, num_checks = 0;
    // ==========================================================
    // Reference model.
    // ==========================================================
    logic [3:0] m_acc = 4'h0, m_breg = 4'h0;
    logic [3:0] m_r [7] = '{default: 4'h0};
    logic [4:0] m_op = 5'h00;
    logic m_ime = 1'b0, m_ext0 = 1'b0, m_skip = 1'b0, m_pin = 1'b0, m_aux = 1'b0;
    logic [7:0] m_ps = 8'h00, m_psr = 8'h00, m_t1 = 8'h00, m_r1l = 8'h00, m_r1h = 8'h00;
    logic [4:0] rd_op [7] = '{5'h05, 5'h07, 5'h09, 5'h0C, 5'h0E, 5'h10, 5'h12};
    logic [4:0] wr_op [7] = '{5'h06, 5'h08, 5'h0A, 5'h0D, 5'h0F, 5'h11, 5'h13};
    itto_core dut (.*);
    itto_ext_src far_end (.clk(clk), .rst_n(rst_n), .pin_req(pin_req), .pulse_req(pulse_req),
        .ext_int_pin(ext_int_pin), .ext0_event(ext0_event));
    // ==========================================================
    // Tasks.
    // ==========================================================
    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            r = s_axi_bresp;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        if (n >= 100) begin
            errors++;
            close_out();
        end
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            d = s_axi_rdata;
            r = s_axi_rresp;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        if (n >= 100) begin
            errors++;
            close_out();
        end
    endtask : axr
    task automatic check_all;
        logic [31:0] d, ctl;
        logic [1:0] r;
        ctl = 32'h0000_0000;
        for (int i = 0; i < 7; i++) ctl[4*i +: 4] = m_r[i];
        axr(itto_pkg::OFF_STATUS, d, r);
        chk("status", {28'h0, m_pin, m_skip, m_ext0, m_ime}, d);
        axr(itto_pkg::OFF_CTRL, d, r);
        chk("ctrl", ctl, d);
        axr(itto_pkg::OFF_TIMER, d, r);
        chk("timer", {16'h0, m_t1, m_ps}, d);
        axr(itto_pkg::OFF_RELOAD, d, r);
        chk("reload", {8'h0, m_r1h, m_r1l, m_psr}, d);
        axr(itto_pkg::OFF_ACC, d, r);
        chk("acc", {28'h0, m_acc}, d);
        axr(itto_pkg::OFF_BREG, d, r);
        chk("breg", {28'h0, m_breg}, d);
        axr(itto_pkg::OFF_CMD, d, r);
        chk("cmd", {27'h0, m_op}, d);
        chk("aux", {31'h0, m_aux}, {31'h0, timer_aux_control});
        chk("flags", 32'({m_skip, m_ext0, m_ime}), 32'({skip_pending, ext0_request_flag, irq_master_enable}));
    endtask : check_all
    task automatic ld(input logic [3:0] a, input logic [3:0] b);
        logic [1:0] r;
        m_acc = a;
        m_breg = b;
        axw(itto_pkg::OFF_ACC, {28'h0, a}, 4'hf, r);
        axw(itto_pkg::OFF_BREG, {28'h0, b}, 4'hf, r);
    endtask : ld
    task automatic cmd(input logic [4:0] op);
        logic [1:0] r;
        m_op = op;
        if (m_skip) begin
            m_skip = 1'b0;
        end else begin
            m_skip = 1'b0;
            for (int i = 0; i < 7; i++) begin
                if (op == rd_op[i]) m_acc = m_r[i];
                if (op == wr_op[i]) m_r[i] = m_acc;
            end
            case (op)
                5'h01: m_ime = 1'b0;
                5'h02: m_ime = 1'b1;
                5'h03: if (!m_r[0][0] && m_ext0) {m_ext0, m_skip} = 2'b01;
                5'h04: m_skip = (m_pin == m_r[2][2]);
                5'h0B: m_aux = m_acc[0];
                5'h14: {m_breg, m_acc} = m_ps;
                5'h15: {m_ps, m_psr} = {2{m_breg, m_acc}};
                5'h16: {m_breg, m_acc} = m_t1;
                5'h17: {m_t1, m_r1l} = {2{m_breg, m_acc}};
                5'h18: m_r1h = {m_breg, m_acc};
                default: m_op = op;
            endcase
        end
        axw(itto_pkg::OFF_CMD, {27'h0, op}, 4'hf, r);
        check_all();
    endtask : cmd
    task automatic pulse;
        @(posedge clk);
        pulse_req <= 1'b1;
        @(posedge clk);
        pulse_req <= 1'b0;
        repeat (2) @(posedge clk);
        m_ext0 = 1'b1;
    endtask : pulse
    // ==========================================================
    // Clock and test sequence.
    // ==========================================================
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        void'($urandom(32'heac8_4db7));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check_all();
        $display("done: reset values");
        cmd(5'h02);
        cmd(5'h01);
        cmd(5'h02);
        cmd(5'h1F);
        $display("done: master enable");
        for (int i = 0; i < 7; i++) begin
            ld(4'($urandom), 4'($urandom));
            cmd(wr_op[i]);
            ld(~m_acc, 4'($urandom));
            cmd(rd_op[i]);
        end
        for (int i = 0; i < 2; i++) begin
            ld(4'(i), 4'h0);
            cmd(5'h0B);
        end
        $display("done: control transfers");
        ld(4'($urandom), 4'($urandom));
        cmd(5'h15);
        ld(4'($urandom), 4'($urandom));
        cmd(5'h17);
        ld(4'($urandom), 4'($urandom));
        cmd(5'h18);
        ld(4'h0, 4'h0);
        cmd(5'h14);
        cmd(5'h16);
        $display("done: timer transfers");
        ld(4'h0, 4'h0);
        cmd(5'h06);
        pulse();
        cmd(5'h03);
        cmd(5'h01);
        cmd(5'h03);
        ld(4'h1, 4'h0);
        cmd(5'h06);
        pulse();
        cmd(5'h03);
        $display("done: request flag test");
        for (int k = 0; k < 4; k++) begin
            pin_req <= k[0];
            m_pin = k[0];
            ld({1'b0, k[1], 2'b00}, 4'h0);
            cmd(5'h0A);
            cmd(5'h04);
            cmd(5'h00);
        end
        $display("done: pin level test");
        axr(8'h1C, d, r);
        chk("bad rd resp", {30'h0, itto_pkg::RESP_SLVERR}, {30'h0, r});
        chk("bad rd data", 32'h0000_0000, d);
        axw(8'h40, 32'h0000_0001, 4'hf, r);
        chk("bad wr resp", {30'h0, itto_pkg::RESP_SLVERR}, {30'h0, r});
        axw(itto_pkg::OFF_ACC, 32'h0000_000F, 4'h0, r);
        axw(itto_pkg::OFF_CTRL, $urandom, 4'hf, r);
        chk("ro wr resp", {30'h0, itto_pkg::RESP_OKAY}, {30'h0, r});
        check_all();
        $display("done: refused accesses");
        close_out();
    end
endmodule : tb_irq_timer_transfer_ops
